/* rtl/watchdog_consts.vh */
// Constants for the watchdog configuration register block
`ifndef WATCHDOG_CONSTS_VH
`define WATCHDOG_CONSTS_VH

// ----------------------------------------------------------------
// Register offsets
// ----------------------------------------------------------------
`define WD_ADDR_W 2
`define WD_OFS_CONTROL 2'h0
`define WD_OFS_WINDOW 2'h1
`define WD_OFS_STATUS 2'h2

// ----------------------------------------------------------------
// Field positions, shared by control and window registers, and the status busy bit
// ----------------------------------------------------------------
`define WD_DATA_W 8
`define WD_BIT_CHANGE 0
`define WD_BIT_ENABLE 1
`define WD_SEL_LO 2
`define WD_SEL_HI 5
`define WD_SEL_W 4
`define WD_BIT_BUSY 0

// ----------------------------------------------------------------
// Reset values and encodings
// ----------------------------------------------------------------
`define WD_ZERO_BYTE 8'h00
`define WD_ZERO_RSV2 2'h0
`define WD_ZERO_RSV7 7'h00
`define WD_SEL_MAX 4'hA
`define WD_SEL_ONE 4'h1

// ----------------------------------------------------------------
// Timing, in watchdog ticks
// ----------------------------------------------------------------
`define WD_CNT_W 14
`define WD_CNT_ZERO 14'h0000
`define WD_CNT_ONE 14'h0001
`define WD_BASE_TICKS 14'h0008
`define WD_SYNC_TICKS 2'h2
`define WD_SYNC_W 2
`define WD_SYNC_ZERO 2'h0
`define WD_SYNC_ONE 2'h1

`endif

/* rtl/watchdog_config_registers.v */
// Watchdog timer with its control, window and status registers
`timescale 1ns/1ps
`default_nettype none
`include "watchdog_consts.vh"

module watchdog_config_registers (
  // Clock and reset
  input wire clk,
  input wire rst_b,
  // Register port
  input wire [`WD_ADDR_W-1:0] addr,
  input wire [`WD_DATA_W-1:0] wrData,
  input wire wrEn,
  input wire rdEn,
  output reg [`WD_DATA_W-1:0] rdData,
  // Protection qualifier and fuses
  input wire cfgUnlock,
  input wire lockFuse,
  input wire [`WD_SEL_W-1:0] periodFuseField,
  input wire [`WD_SEL_W-1:0] windowPeriodFuseField,
  input wire enableFuse,
  input wire windowEnableFuse,
  // Watchdog clock and restart
  input wire lowPowerOscTick,
  input wire watchdogRestartInstr,
  // Reset request
  output reg watchdogReset
);

  // ----------------------------------------------------------------
  // Timer states
  // ----------------------------------------------------------------
  localparam [2:0] ST_IDLE = 3'h1;
  localparam [2:0] ST_CLOSED = 3'h2;
  localparam [2:0] ST_OPEN = 3'h4;

  // Ticks for a period code, zero for a reserved code
  function [`WD_CNT_W-1:0] selTicks;
    input [`WD_SEL_W-1:0] sel;
    begin
      if (sel > `WD_SEL_MAX) begin
        selTicks = `WD_CNT_ZERO;
      end else begin
        selTicks = `WD_BASE_TICKS << sel;
      end
    end
  endfunction

  // ----------------------------------------------------------------
  // Register state
  // ----------------------------------------------------------------
  reg [`WD_SEL_W-1:0] periodSel_q;
  reg enable_q;
  reg ctrlChange_q;
  reg [`WD_SEL_W-1:0] windowSel_q;
  reg windowEnable_q;
  reg windowChange_q;
  reg sync_pending_flag_q;
  reg [`WD_SYNC_W-1:0] syncCnt_q;

  // Next values of the register state
  reg [`WD_SEL_W-1:0] periodSel_d;
  reg enable_d;
  reg ctrlChange_d;
  reg [`WD_SEL_W-1:0] windowSel_d;
  reg windowEnable_d;
  reg windowChange_d;
  reg sync_pending_flag_d;
  reg [`WD_SYNC_W-1:0] syncCnt_d;
  reg [`WD_SEL_W-1:0] effPeriod_d;
  reg [`WD_SEL_W-1:0] effWindow_d;
  reg effEnable_d;
  reg effWindowEn_d;
  reg [`WD_DATA_W-1:0] rdData_d;

  // Settings in use by the timer, taken over at end of crossing
  reg [`WD_SEL_W-1:0] effPeriod_q;
  reg [`WD_SEL_W-1:0] effWindow_q;
  reg effEnable_q;
  reg effWindowEn_q;

  // Tick synchroniser and edge detect
  reg tickMeta_q;
  reg tickSync_q;
  reg tickPrev_q;
  wire tick;

  // Timer state
  reg [2:0] state_q;
  reg [2:0] state_d;
  reg [`WD_CNT_W-1:0] count_q;
  reg [`WD_CNT_W-1:0] count_d;
  reg fire_d;

  // Write qualifiers, crossing completion and timer tick counts
  wire wrOk;
  wire ctrlWr;
  wire winWr;
  wire syncDone;
  wire [`WD_CNT_W-1:0] openTicks;
  wire [`WD_CNT_W-1:0] closedTicks;
  wire [`WD_CNT_W-1:0] countInc;

  // ----------------------------------------------------------------
  // Write decode
  // ----------------------------------------------------------------
  assign wrOk = wrEn & cfgUnlock;
  assign ctrlWr = wrOk & (addr == `WD_OFS_CONTROL) & ~lockFuse;
  assign winWr = wrOk & (addr == `WD_OFS_WINDOW);

  // Control register next value; fields move only with change bit
  always @* begin
    periodSel_d = periodSel_q;
    enable_d = enable_q;
    ctrlChange_d = ctrlChange_q;
    if (ctrlWr) begin
      ctrlChange_d = wrData[`WD_BIT_CHANGE];
      if (wrData[`WD_BIT_CHANGE]) begin
        periodSel_d = wrData[`WD_SEL_HI:`WD_SEL_LO];
        enable_d = wrData[`WD_BIT_ENABLE];
      end
    end
  end

  // Control register
  always @(posedge clk) begin
    if (!rst_b) begin
      periodSel_q <= periodFuseField;
      enable_q <= enableFuse;
      ctrlChange_q <= 1'b0;
    end else begin
      periodSel_q <= periodSel_d;
      enable_q <= enable_d;
      ctrlChange_q <= ctrlChange_d;
    end
  end

  // Window register next value; mode bits stay writable when locked
  always @* begin
    windowSel_d = windowSel_q;
    windowEnable_d = windowEnable_q;
    windowChange_d = windowChange_q;
    if (winWr) begin
      windowChange_d = wrData[`WD_BIT_CHANGE];
      if (wrData[`WD_BIT_CHANGE]) begin
        windowEnable_d = wrData[`WD_BIT_ENABLE];
        if (!lockFuse) begin
          windowSel_d = wrData[`WD_SEL_HI:`WD_SEL_LO];
        end
      end
    end
  end

  // Window register
  always @(posedge clk) begin
    if (!rst_b) begin
      windowSel_q <= windowPeriodFuseField;
      windowEnable_q <= windowEnableFuse;
      windowChange_q <= 1'b0;
    end else begin
      windowSel_q <= windowSel_d;
      windowEnable_q <= windowEnable_d;
      windowChange_q <= windowChange_d;
    end
  end

  // ----------------------------------------------------------------
  // Watchdog tick
  // ----------------------------------------------------------------
  // Two-stage synchroniser, then rising edge on the settled copy
  always @(posedge clk) begin
    if (!rst_b) begin
      tickMeta_q <= 1'b0;
      tickSync_q <= 1'b0;
      tickPrev_q <= 1'b0;
    end else begin
      tickMeta_q <= lowPowerOscTick;
      tickSync_q <= tickMeta_q;
      tickPrev_q <= tickSync_q;
    end
  end

  assign tick = tickSync_q & ~tickPrev_q;

  // ----------------------------------------------------------------
  // Crossing into the tick domain
  // ----------------------------------------------------------------
  // Done after the set number of ticks; runs only while enabled
  assign syncDone = sync_pending_flag_q & tick & (enable_q | effEnable_q) &
                    (syncCnt_q == (`WD_SYNC_TICKS - `WD_SYNC_ONE));

  // Busy flag next value: a new write wins over completion
  always @* begin
    sync_pending_flag_d = sync_pending_flag_q;
    syncCnt_d = syncCnt_q;
    if (ctrlWr | winWr) begin
      sync_pending_flag_d = 1'b1;
      syncCnt_d = `WD_SYNC_ZERO;
    end else if (syncDone) begin
      sync_pending_flag_d = 1'b0;
      syncCnt_d = `WD_SYNC_ZERO;
    end else if (sync_pending_flag_q & tick & (enable_q | effEnable_q)) begin
      syncCnt_d = syncCnt_q + `WD_SYNC_ONE;
    end
  end

  // Busy flag and crossing counter
  always @(posedge clk) begin
    if (!rst_b) begin
      sync_pending_flag_q <= 1'b0;
      syncCnt_q <= `WD_SYNC_ZERO;
    end else begin
      sync_pending_flag_q <= sync_pending_flag_d;
      syncCnt_q <= syncCnt_d;
    end
  end

  // Settings taken over only when the crossing completes
  always @* begin
    effPeriod_d = effPeriod_q;
    effWindow_d = effWindow_q;
    effEnable_d = effEnable_q;
    effWindowEn_d = effWindowEn_q;
    if (syncDone) begin
      effPeriod_d = periodSel_q;
      effWindow_d = windowSel_q;
      effEnable_d = enable_q;
      effWindowEn_d = windowEnable_q;
    end
  end

  // Settings seen by the timer
  always @(posedge clk) begin
    if (!rst_b) begin
      effPeriod_q <= periodFuseField;
      effWindow_q <= windowPeriodFuseField;
      effEnable_q <= enableFuse;
      effWindowEn_q <= windowEnableFuse;
    end else begin
      effPeriod_q <= effPeriod_d;
      effWindow_q <= effWindow_d;
      effEnable_q <= effEnable_d;
      effWindowEn_q <= effWindowEn_d;
    end
  end

  // ----------------------------------------------------------------
  // Timeout timer
  // ----------------------------------------------------------------
  assign openTicks = selTicks(effPeriod_q);
  assign closedTicks = selTicks(effWindow_q);
  assign countInc = count_q + `WD_CNT_ONE;

  // Next state of the timer
  always @* begin
    state_d = state_q;
    count_d = count_q;
    fire_d = 1'b0;
    case (state_q)
      ST_IDLE: begin
        count_d = `WD_CNT_ZERO;
        if (effEnable_q) begin
          state_d = effWindowEn_q ? ST_CLOSED : ST_OPEN;
        end
      end
      ST_CLOSED: begin
        if (!effEnable_q) begin
          state_d = ST_IDLE;
        end else if (watchdogRestartInstr) begin
          fire_d = 1'b1;
          count_d = `WD_CNT_ZERO;
        end else if (!effWindowEn_q || closedTicks == `WD_CNT_ZERO) begin
          state_d = ST_OPEN;
          count_d = `WD_CNT_ZERO;
        end else if (tick) begin
          if (countInc >= closedTicks) begin
            state_d = ST_OPEN;
            count_d = `WD_CNT_ZERO;
          end else begin
            count_d = countInc;
          end
        end
      end
      ST_OPEN: begin
        if (!effEnable_q) begin
          state_d = ST_IDLE;
        end else if (watchdogRestartInstr) begin
          state_d = effWindowEn_q ? ST_CLOSED : ST_OPEN;
          count_d = `WD_CNT_ZERO;
        end else if (tick && openTicks != `WD_CNT_ZERO) begin
          if (countInc >= openTicks) begin
            fire_d = 1'b1;
            state_d = effWindowEn_q ? ST_CLOSED : ST_OPEN;
            count_d = `WD_CNT_ZERO;
          end else begin
            count_d = countInc;
          end
        end
      end
      default: begin
        state_d = ST_IDLE;
        count_d = `WD_CNT_ZERO;
      end
    endcase
  end

  // Timer registers and reset request
  always @(posedge clk) begin
    if (!rst_b) begin
      state_q <= ST_IDLE;
      count_q <= `WD_CNT_ZERO;
      watchdogReset <= 1'b0;
    end else begin
      state_q <= state_d;
      count_q <= count_d;
      watchdogReset <= fire_d;
    end
  end

  // ----------------------------------------------------------------
  // Read port
  // ----------------------------------------------------------------
  // Read data next value, zero when no strobe
  always @* begin
    rdData_d = `WD_ZERO_BYTE;
    if (rdEn) begin
      case (addr)
        `WD_OFS_CONTROL: begin
          rdData_d = {`WD_ZERO_RSV2, periodSel_q, enable_q, ctrlChange_q};
        end
        `WD_OFS_WINDOW: begin
          rdData_d = {`WD_ZERO_RSV2, windowSel_q, windowEnable_q, windowChange_q};
        end
        `WD_OFS_STATUS: begin
          rdData_d = {`WD_ZERO_RSV7, sync_pending_flag_q};
        end
        default: begin
          rdData_d = `WD_ZERO_BYTE;
        end
      endcase
    end
  end

  // Read data valid in the cycle after the strobe only
  always @(posedge clk) begin
    if (!rst_b) begin
      rdData <= `WD_ZERO_BYTE;
    end else begin
      rdData <= rdData_d;
    end
  end

endmodule
`default_nettype wire

/* tb/watchdog_config_registers_asserts.sv */
// Port checker for the watchdog configuration register block
`timescale 1ns/1ps
`default_nettype none
module watchdog_config_registers_asserts (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_b,
  // Register port
  input wire logic [1:0] addr,
  input wire logic [7:0] wrData,
  input wire logic wrEn,
  input wire logic rdEn,
  input wire logic [7:0] rdData,
  // Qualifiers and timer
  input wire logic cfgUnlock,
  input wire logic lockFuse,
  input wire logic lowPowerOscTick,
  input wire logic watchdogRestartInstr,
  input wire logic watchdogReset
);
  logic tickQ;
  logic [3:0] sinceTick;
  // Cycles since the oscillator pin last rose
  always_ff @(posedge clk) begin
    tickQ <= lowPowerOscTick;
    if (lowPowerOscTick && !tickQ) sinceTick <= 4'h0;
    else if (!rst_b) sinceTick <= 4'hF;
    else if (sinceTick != 4'hF) sinceTick <= sinceTick + 4'h1;
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_b);
  property p_rsv; $past(rdEn) |-> rdData[7:6] == 2'h0; endproperty
  a_rsv: assert property (p_rsv) else $error("upper bits set");
  property p_stat; $past(rdEn && addr == 2'h2) |-> rdData[7:1] == 7'h00; endproperty
  a_stat: assert property (p_stat) else $error("status upper bits set");
  property p_unmap; $past(rdEn && addr == 2'h3) |-> rdData == 8'h00; endproperty
  a_unmap: assert property (p_unmap) else $error("unmapped read not zero");
  property p_pulse; watchdogReset |=> !watchdogReset; endproperty
  a_pulse: assert property (p_pulse) else $error("reset pulse too long");
  property p_cause; watchdogReset |-> sinceTick <= 4'h6 || $past(watchdogRestartInstr); endproperty
  a_cause: assert property (p_cause) else $error("reset without cause");
  property p_ctrl; (wrEn && cfgUnlock && !lockFuse && addr == 2'h0 && wrData[0]) ##2
    (rdEn && addr == 2'h0) |=> rdData == ($past(wrData, 3) & 8'h3F); endproperty
  a_ctrl: assert property (p_ctrl) else $error("control write lost");
  property p_win; (wrEn && cfgUnlock && !lockFuse && addr == 2'h1 && wrData[0]) ##2
    (rdEn && addr == 2'h1) |=> rdData == ($past(wrData, 3) & 8'h3F); endproperty
  a_win: assert property (p_win) else $error("window write lost");
  property p_busy; (wrEn && cfgUnlock && !lockFuse && !addr[1]) ##2
    (rdEn && addr == 2'h2) |=> rdData == 8'h01; endproperty
  a_busy: assert property (p_busy) else $error("busy not raised");
  property p_refuse; (rdEn && addr == 2'h0) ##2 (wrEn && addr == 2'h0 && (!cfgUnlock || lockFuse))
    ##2 (rdEn && addr == 2'h0) |=> rdData == $past(rdData, 4); endproperty
  a_refuse: assert property (p_refuse) else $error("refused write changed");
endmodule
bind watchdog_config_registers watchdog_config_registers_asserts assertChecker (.clk(clk),
  .rst_b(rst_b), .addr(addr), .wrData(wrData), .wrEn(wrEn), .rdEn(rdEn), .rdData(rdData),
  .cfgUnlock(cfgUnlock), .lockFuse(lockFuse), .lowPowerOscTick(lowPowerOscTick),
  .watchdogRestartInstr(watchdogRestartInstr), .watchdogReset(watchdogReset));
`default_nettype wire

/* tb/test_watchdog_config_registers.sv */
// Testbench for the watchdog configuration register block
`timescale 1ns/1ps
`default_nettype none
module test_watchdog_config_registers;
  logic clk = 0, rst_b = 0, wrEn = 0, rdEn = 0, cfgUnlock = 0, lockFuse = 0;
  logic oscTick = 0, restartReq = 0;
  logic [1:0] addr = 0;
  logic [7:0] wrData = 0, got;
  wire [7:0] rdData;
  wire wdReset;
  int n_errors = 0, samples_checked = 0, ticks = 0;
  // Clocks and tick count
  always #5 clk = ~clk;
  always #50 oscTick = ~oscTick;
  always @(posedge oscTick) ticks++;
  watchdog_config_registers dut (.clk(clk), .rst_b(rst_b), .addr(addr), .wrData(wrData),
    .wrEn(wrEn), .rdEn(rdEn), .rdData(rdData), .cfgUnlock(cfgUnlock), .lockFuse(lockFuse),
    .periodFuseField(4'h3), .windowPeriodFuseField(4'h5), .enableFuse(1'b1),
    .windowEnableFuse(1'b0), .lowPowerOscTick(oscTick), .watchdogRestartInstr(restartReq),
    .watchdogReset(wdReset));
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      n_errors++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic wr(input logic [1:0] a, input logic [7:0] d, input logic u);
    @(posedge clk);
    addr <= a;
    wrData <= d;
    cfgUnlock <= u;
    wrEn <= 1;
    @(posedge clk);
    wrEn <= 0;
    cfgUnlock <= 0;
  endtask
  task automatic rc(input logic [1:0] a, input logic [7:0] e, input logic doChk = 1);
    @(posedge clk);
    addr <= a;
    rdEn <= 1;
    @(posedge clk);
    rdEn <= 0;
    #1 got = rdData;
    if (doChk) chk(16'(got), 16'(e));
  endtask
  task automatic idle;
    int k;
    for (k = 0; k < 100; k++) begin
      rc(2'h2, 8'h00, 1'b0);
      if (got === 8'h00) break;
    end
    chk(16'(got), 16'h0000);
  endtask
  task automatic set(input logic [1:0] a, input logic [7:0] d);
    wr(a, d, 1'b1);
    rc(2'h2, 8'h01);
    idle;
  endtask
  task automatic kick;
    @(posedge oscTick);
    repeat (5) @(posedge clk);
    restartReq <= 1;
    @(posedge clk);
    restartReq <= 0;
  endtask
  task automatic waitRst(input int lim);
    int k;
    for (k = 0; k < lim * 10; k++) begin
      @(posedge clk);
      #1;
      if (wdReset === 1'b1) break;
    end
  endtask
  task automatic meas(input int n, input int lim);
    int t0;
    kick;
    t0 = ticks;
    waitRst(lim);
    chk(wdReset === 1'b1 ? 16'(ticks - t0) : 16'h0000, 16'(n));
  endtask
  task automatic t_reset;
    rc(2'h1, 8'h14);
    rc(2'h2, 8'h00);
    rc(2'h3, 8'h00);
    rc(2'h0, 8'h0E);
  endtask
  task automatic t_refuse;
    wr(2'h0, 8'h2B, 1'b0);
    rc(2'h0, 8'h0E);
    rc(2'h2, 8'h00);
    wr(2'h0, 8'h2A, 1'b1);
    rc(2'h0, 8'h0E);
    idle;
    wr(2'h0, 8'h0F, 1'b1);
    rc(2'h0, 8'h0F);
    idle;
  endtask
  task automatic t_normal;
    int c;
    for (c = 0; c < 9; c++) begin
      set(2'h0, 8'(c * 4 + 3));
      meas(8 << c, (8 << c) + 8);
    end
    for (c = 11; c < 16; c++) begin
      set(2'h0, 8'(c * 4 + 3));
      meas(0, 24);
    end
  endtask
  task automatic t_window;
    set(2'h0, 8'h03);
    set(2'h1, 8'h2F);
    meas(8, 16);
    wr(2'h1, 8'h03, 1'b1);
    rc(2'h1, 8'h03);
    idle;
    waitRst(40);
    repeat (10) @(posedge oscTick);
    meas(16, 24);
    kick;
    #1 chk(16'(wdReset), 16'h0001);
    set(2'h1, 8'h15);
    meas(8, 16);
  endtask
  task automatic t_disable;
    set(2'h0, 8'h01);
    meas(0, 24);
    wr(2'h1, 8'h03, 1'b1);
    repeat (4) @(posedge oscTick);
    rc(2'h2, 8'h01);
    set(2'h0, 8'h03);
  endtask
  task automatic t_lock;
    @(posedge clk);
    lockFuse <= 1;
    rst_b <= 0;
    repeat (16) @(posedge clk);
    rst_b <= 1;
    wr(2'h0, 8'h01, 1'b1);
    rc(2'h0, 8'h0E);
    wr(2'h1, 8'h03, 1'b1);
    rc(2'h1, 8'h17);
  endtask
  task automatic final_report;
    $display("checks %0d errors %0d", samples_checked, n_errors);
    if (n_errors == 0 && samples_checked > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  // Main sequence
  initial begin
    repeat (16) @(posedge clk);
    rst_b <= 1;
    t_reset;
    t_refuse;
    t_normal;
    t_window;
    t_disable;
    t_lock;
    final_report;
  end
  // Hang guard
  initial begin
    #1000000;
    n_errors++;
    final_report;
  end
endmodule
`default_nettype wire
